// ---- inc/dors_pkg.sv ----
/*
  constants for the dds register select and output block.
  assumes a single master clock domain; words arrive already deframed.
*/
package dors_pkg;
  localparam int FREQ_W = 28;
  localparam int FREQ_HALF_W = 14;
  localparam int PHASE_W = 12;
  localparam int DAC_W = 10;
  localparam int DAC_MSB = DAC_W - 1;
  localparam int WORD_W = 16;
  localparam int CTRL_W = 14;
  localparam int LUT_IDX_W = 4;
  localparam int LUT_AMP_W = 9;
  // word address field and decode
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_FREQ_A = 2'h1;
  localparam logic [1:0] ADDR_FREQ_B = 2'h2;
  localparam logic [1:0] ADDR_PHASE = 2'h3;
  localparam int PHASE_TARGET_BIT = 13;
  // control word field positions
  localparam int FULL_WORD_BIT = 13;
  localparam int HIGH_HALF_BIT = 12;
  localparam int FREQ_CHOICE_BIT = 11;
  localparam int PHASE_CHOICE_BIT = 10;
  localparam int CTRL_SOURCE_BIT = 9;
  localparam int OUT_PIN_EN_BIT = 5;
  localparam int CMP_MSB_SEL_BIT = 4;
  localparam int HALVE_BYPASS_BIT = 3;
  localparam int WAVE_MODE_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 28'h0000000;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 12'h000;
  localparam logic [DAC_W-1:0] DAC_MID = 10'h200;

  // quarter-wave sine amplitude, sampled at bin centres
  function automatic logic [LUT_AMP_W-1:0] sine_quarter(input logic [LUT_IDX_W-1:0] idx);
    logic [LUT_AMP_W-1:0] amp;
    amp = 9'h000;
    unique case (idx)
      4'h0: amp = 9'h019;
      4'h1: amp = 9'h04B;
      4'h2: amp = 9'h07C;
      4'h3: amp = 9'h0AC;
      4'h4: amp = 9'h0DA;
      4'h5: amp = 9'h107;
      4'h6: amp = 9'h130;
      4'h7: amp = 9'h157;
      4'h8: amp = 9'h17B;
      4'h9: amp = 9'h19A;
      4'hA: amp = 9'h1B6;
      4'hB: amp = 9'h1CE;
      4'hC: amp = 9'h1E1;
      4'hD: amp = 9'h1F0;
      4'hE: amp = 9'h1F9;
      4'hF: amp = 9'h1FE;
    endcase
    return amp;
  endfunction
endpackage

// ---- inc/dors_link_if.sv ----
/*
  carrier between the select logic and the waveform core.
  assumes both ends sit on the same master clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface dors_link_if;
  logic [dors_pkg::FREQ_W-1:0] freqWord;
  logic [dors_pkg::PHASE_W-1:0] phaseWord;
  logic triangleMode;
  logic [dors_pkg::DAC_W-1:0] dacWord;
  modport core (
    input freqWord,
    input phaseWord,
    input triangleMode,
    output dacWord
  );
  modport ctrl (
    output freqWord,
    output phaseWord,
    output triangleMode,
    input dacWord
  );
endinterface
`default_nettype wire

// ---- rtl/dors_wave.sv ----
/*
  phase accumulator, phase offset add and waveform stage.
  assumes selected words come from the select logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dors_wave (
  input wire logic ref_clk,
  input wire logic srst,
  dors_link_if.core link
);
  // ==========================================================
  // accumulator and phase
  logic [dors_pkg::FREQ_W-1:0] phaseAcc;
  logic [dors_pkg::PHASE_W-1:0] phaseSum;
  logic [dors_pkg::LUT_IDX_W-1:0] lutIdx;
  logic [dors_pkg::LUT_AMP_W-1:0] lutAmp;
  logic [dors_pkg::DAC_W-1:0] sineVal;
  logic [dors_pkg::DAC_W-1:0] triVal;
  logic [dors_pkg::DAC_W-1:0] next_dacWord;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phaseAcc <= dors_pkg::FREQ_RESET;
    end else begin
      phaseAcc <= phaseAcc + link.freqWord;
    end
  end

  assign phaseSum = phaseAcc[dors_pkg::FREQ_W-1 -: dors_pkg::PHASE_W] + link.phaseWord;

  // ==========================================================
  // waveform select
  // odd quadrants read the quarter table backwards
  assign lutIdx = phaseSum[dors_pkg::PHASE_W-2] ? ~phaseSum[dors_pkg::PHASE_W-3 -: dors_pkg::LUT_IDX_W]
                                                : phaseSum[dors_pkg::PHASE_W-3 -: dors_pkg::LUT_IDX_W];
  assign lutAmp = dors_pkg::sine_quarter(lutIdx);
  assign sineVal = phaseSum[dors_pkg::PHASE_W-1] ? dors_pkg::DAC_MID - 10'h001 - {1'b0, lutAmp}
                                                 : dors_pkg::DAC_MID + {1'b0, lutAmp};
  assign triVal = phaseSum[dors_pkg::PHASE_W-1] ? ~phaseSum[dors_pkg::PHASE_W-2:1]
                                                : phaseSum[dors_pkg::PHASE_W-2:1];
  assign next_dacWord = link.triangleMode ? triVal : sineVal;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link.dacWord <= dors_pkg::DAC_MID;
    end else begin
      link.dacWord <= next_dacWord;
    end
  end

  // ==========================================================
  // checks
  AST_ACCUM: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(srst) |-> phaseAcc == $past(phaseAcc) + $past(link.freqWord))
    else $error("accumulator did not add the selected word");
  AST_TRIANGLE: assert property (@(posedge ref_clk) disable iff (srst)
    link.triangleMode && !phaseSum[dors_pkg::PHASE_W-1] |=> link.dacWord == $past(phaseSum[dors_pkg::PHASE_W-2:1]))
    else $error("triangle output does not follow phase");
  AST_SINE_HALF: assert property (@(posedge ref_clk) disable iff (srst)
    !link.triangleMode |=> link.dacWord[dors_pkg::DAC_MSB] == !$past(phaseSum[dors_pkg::PHASE_W-1]))
    else $error("sine half does not match phase");
endmodule // dors_wave
`default_nettype wire

// ---- rtl/dors_top.sv ----
/*
  register file, register selection and square output path of a dds.
  assumes 16-bit words arrive deframed, one per wordValid pulse, on ref_clk;
  select pins and comparator are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module dors_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [15:0] wordData,
  input wire logic wordValid,
  input wire logic frequencyChoicePin,
  input wire logic phaseChoicePin,
  input wire logic comparatorIn,
  output logic [9:0] dacData,
  output logic squareOut,
  output logic squareOutEnN
);
  // ==========================================================
  // declarations
  dors_link_if link ();

  logic [dors_pkg::CTRL_W-1:0] controlWord;
  logic [dors_pkg::FREQ_W-1:0] selected_frequency_value [2];
  logic [dors_pkg::PHASE_W-1:0] selected_phase_value [2];
  logic [1:0] pendingHigh;

  logic [1:0] wordAddr;
  logic writeCtrl;
  logic writePhase;
  logic [1:0] writeFreq;
  logic [1:0] loadHigh;
  logic phaseTarget;
  logic fullWord;
  logic highHalf;

  logic pinSource;
  logic useFreqB;
  logic usePhaseB;
  logic cmpSel;
  logic bypass;
  logic pinEnable;

  logic freqPinFall;
  logic freqPinSync;
  logic phasePinFall;
  logic phasePinSync;
  logic compMeta;
  logic compSync;

  logic chosenDigital;
  logic chosenPrev;
  logic halfToggle;
  logic next_squareOut;

  // ==========================================================
  // word decode
  assign wordAddr = wordData[dors_pkg::ADDR_HI:dors_pkg::ADDR_LO];
  assign writeCtrl = wordValid && (wordAddr == dors_pkg::ADDR_CONTROL);
  assign writeFreq[0] = wordValid && (wordAddr == dors_pkg::ADDR_FREQ_A);
  assign writeFreq[1] = wordValid && (wordAddr == dors_pkg::ADDR_FREQ_B);
  assign writePhase = wordValid && (wordAddr == dors_pkg::ADDR_PHASE);
  assign phaseTarget = wordData[dors_pkg::PHASE_TARGET_BIT];
  assign fullWord = controlWord[dors_pkg::FULL_WORD_BIT];
  assign highHalf = controlWord[dors_pkg::HIGH_HALF_BIT];
  // full-word mode alternates halves, low half first
  assign loadHigh = fullWord ? pendingHigh : {2{highHalf}};

  // ==========================================================
  // register file
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      controlWord <= dors_pkg::CTRL_RESET;
    end else if (writeCtrl) begin
      controlWord <= wordData[dors_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pendingHigh <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        selected_frequency_value[i] <= dors_pkg::FREQ_RESET;
        selected_phase_value[i] <= dors_pkg::PHASE_RESET;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (writeFreq[i] && loadHigh[i]) begin
          selected_frequency_value[i][dors_pkg::FREQ_W-1 -: dors_pkg::FREQ_HALF_W] <= wordData[dors_pkg::FREQ_HALF_W-1:0];
        end
        if (writeFreq[i] && !loadHigh[i]) begin
          selected_frequency_value[i][dors_pkg::FREQ_HALF_W-1:0] <= wordData[dors_pkg::FREQ_HALF_W-1:0];
        end
        if (writePhase && (phaseTarget == i[0])) begin
          selected_phase_value[i] <= wordData[dors_pkg::PHASE_W-1:0];
        end
        if (writeCtrl) begin
          pendingHigh[i] <= 1'b0;
        end else if (writeFreq[i] && fullWord) begin
          pendingHigh[i] <= ~pendingHigh[i];
        end
      end
    end
  end

  // ==========================================================
  // pin sampling
  // pins are caught on the falling edge, then retimed to the rising edge
  always_ff @(negedge ref_clk) begin
    if (srst) begin
      freqPinFall <= 1'b0;
      phasePinFall <= 1'b0;
    end else begin
      freqPinFall <= frequencyChoicePin;
      phasePinFall <= phaseChoicePin;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      freqPinSync <= 1'b0;
      phasePinSync <= 1'b0;
      compMeta <= 1'b0;
      compSync <= 1'b0;
    end else begin
      freqPinSync <= freqPinFall;
      phasePinSync <= phasePinFall;
      compMeta <= comparatorIn;
      compSync <= compMeta;
    end
  end

  // ==========================================================
  // register selection
  assign pinSource = controlWord[dors_pkg::CTRL_SOURCE_BIT];
  assign useFreqB = pinSource ? freqPinSync : controlWord[dors_pkg::FREQ_CHOICE_BIT];
  assign usePhaseB = pinSource ? phasePinSync : controlWord[dors_pkg::PHASE_CHOICE_BIT];
  assign link.freqWord = useFreqB ? selected_frequency_value[1] : selected_frequency_value[0];
  assign link.phaseWord = usePhaseB ? selected_phase_value[1] : selected_phase_value[0];
  assign link.triangleMode = controlWord[dors_pkg::WAVE_MODE_BIT];

  dors_wave u_wave (
    .ref_clk(ref_clk),
    .srst(srst),
    .link(link)
  );

  assign dacData = link.dacWord;

  // ==========================================================
  // square output path
  assign cmpSel = controlWord[dors_pkg::CMP_MSB_SEL_BIT];
  assign bypass = controlWord[dors_pkg::HALVE_BYPASS_BIT];
  assign pinEnable = controlWord[dors_pkg::OUT_PIN_EN_BIT];
  assign chosenDigital = cmpSel ? compSync : link.dacWord[dors_pkg::DAC_MSB];
  assign next_squareOut = bypass ? chosenDigital : halfToggle;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // idle level of the dac msb at reset, so no false edge follows reset
      chosenPrev <= dors_pkg::DAC_MID[dors_pkg::DAC_MSB];
      halfToggle <= 1'b0;
      squareOut <= 1'b0;
    end else begin
      chosenPrev <= chosenDigital;
      // one toggle per rising edge halves the frequency
      if (chosenDigital && !chosenPrev) begin
        halfToggle <= ~halfToggle;
      end
      squareOut <= next_squareOut;
    end
  end

  // enable low drives the pin
  assign squareOutEnN = !pinEnable;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence riseSeen;
    !bypass && !writeCtrl && chosenDigital && !chosenPrev;
  endsequence

  sequence quietCycle;
    !writeCtrl;
  endsequence

  AST_OUT_ENABLE: assert property (
    writeCtrl |=> squareOutEnN == !$past(wordData[dors_pkg::OUT_PIN_EN_BIT]))
    else $error("pin enable does not follow control write");
  AST_CMP_ROUTE: assert property (
    cmpSel && bypass && !writeCtrl |=> squareOut == $past(compSync))
    else $error("comparator not routed to square pin");
  AST_MSB_ROUTE: assert property (
    !cmpSel && bypass && !writeCtrl |=> squareOut == $past(link.dacWord[dors_pkg::DAC_MSB]))
    else $error("data msb not routed to square pin");
  AST_HALVE: assert property (
    riseSeen ##1 quietCycle |=> $changed(squareOut))
    else $error("halved output did not toggle on rising edge");
  AST_FREQ_LOW: assert property (
    writeFreq[0] && !loadHigh[0] |=>
      selected_frequency_value[0][dors_pkg::FREQ_HALF_W-1:0] == $past(wordData[dors_pkg::FREQ_HALF_W-1:0]))
    else $error("low half of frequency a not loaded");
  AST_FREQ_SEL: assert property (
    writeCtrl && !wordData[dors_pkg::CTRL_SOURCE_BIT] |=>
      link.freqWord == ($past(wordData[dors_pkg::FREQ_CHOICE_BIT]) ? selected_frequency_value[1] : selected_frequency_value[0]))
    else $error("frequency register choice does not follow control bit");
  AST_PHASE_SEL: assert property (
    writeCtrl && !wordData[dors_pkg::CTRL_SOURCE_BIT] |=>
      link.phaseWord == ($past(wordData[dors_pkg::PHASE_CHOICE_BIT]) ? selected_phase_value[1] : selected_phase_value[0]))
    else $error("phase register choice does not follow control bit");
  AST_PIN_FOLLOW: assert property (
    (pinSource && !writeCtrl && frequencyChoicePin == $past(frequencyChoicePin))[*3] |->
      useFreqB == frequencyChoicePin)
    else $error("frequency choice does not follow pin");
  AST_PHASE_PIN: assert property (
    (pinSource && !writeCtrl && phaseChoicePin == $past(phaseChoicePin))[*3] |->
      usePhaseB == phaseChoicePin)
    else $error("phase choice does not follow pin");

  // ==========================================================
  // register load checks
  // two halves one idle cycle apart in full-word mode build the whole word
  sequence freqLowLoad;
    fullWord && writeFreq[0] && !pendingHigh[0];
  endsequence

  sequence freqHighLoad;
    !wordValid ##1 writeFreq[0];
  endsequence

  AST_FREQ_PAIR: assert property (
    freqLowLoad ##1 freqHighLoad |=>
      selected_frequency_value[0] == {$past(wordData[dors_pkg::FREQ_HALF_W-1:0]), $past(wordData[dors_pkg::FREQ_HALF_W-1:0], 3)})
    else $error("full-word pair did not build frequency a");
  AST_FREQ_HIGH: assert property (
    writeFreq[0] && loadHigh[0] |=>
      selected_frequency_value[0][dors_pkg::FREQ_W-1 -: dors_pkg::FREQ_HALF_W] == $past(wordData[dors_pkg::FREQ_HALF_W-1:0]))
    else $error("high half of frequency a not loaded");
  AST_FREQ_B_LOW: assert property (
    writeFreq[1] && !loadHigh[1] |=>
      selected_frequency_value[1][dors_pkg::FREQ_HALF_W-1:0] == $past(wordData[dors_pkg::FREQ_HALF_W-1:0]))
    else $error("low half of frequency b not loaded");
  AST_FREQ_B_HIGH: assert property (
    writeFreq[1] && loadHigh[1] |=>
      selected_frequency_value[1][dors_pkg::FREQ_W-1 -: dors_pkg::FREQ_HALF_W] == $past(wordData[dors_pkg::FREQ_HALF_W-1:0]))
    else $error("high half of frequency b not loaded");
  AST_PHASE_A_LOAD: assert property (
    writePhase && !phaseTarget |=> selected_phase_value[0] == $past(wordData[dors_pkg::PHASE_W-1:0]))
    else $error("phase offset a not loaded");
  AST_PHASE_B_LOAD: assert property (
    writePhase && phaseTarget |=> selected_phase_value[1] == $past(wordData[dors_pkg::PHASE_W-1:0]))
    else $error("phase offset b not loaded");
  AST_ALTERNATE: assert property (
    fullWord && writeFreq[0] |=> pendingHigh[0] != $past(pendingHigh[0]))
    else $error("full-word halves did not alternate");
  AST_CTRL_REARM: assert property (
    writeCtrl |=> pendingHigh == 2'h0)
    else $error("control write did not restart the half order");

  // ==========================================================
  // selection and output checks
  AST_PIN_IGNORED: assert property (
    !pinSource && !$past(writeCtrl) && $changed(freqPinSync) |-> $stable(useFreqB))
    else $error("frequency choice followed pin while bits select");
  AST_TOGGLE_HOLD: assert property (
    !(chosenDigital && !chosenPrev) |=> $stable(halfToggle))
    else $error("halving stage toggled without a rising edge");
  AST_CMP_SYNC: assert property (
    !$past(srst) && !$past(srst, 2) |-> compSync == $past(comparatorIn, 2))
    else $error("comparator path lost its two-stage retime");
  AST_ENABLE_HOLD: assert property (
    !writeCtrl |=> $stable(squareOutEnN))
    else $error("pin enable moved without a control write");
endmodule // dors_top
`default_nettype wire

// ---- dv/dors_host.sv ----
/*
  host model: writes deframed words and drives the select and comparator pins.
  assumes the design samples words on the rising edge of ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dors_host (
  input wire logic ref_clk,
  output logic [15:0] wordData,
  output logic wordValid,
  output logic frequencyChoicePin,
  output logic phaseChoicePin,
  output logic comparatorIn
);
  logic fullWordMode;
  logic highHalfMode;
  logic [2:0] spareBits;
  initial begin
    wordData = 16'h0000;
    wordValid = 1'b0;
    frequencyChoicePin = 1'b0;
    phaseChoicePin = 1'b0;
    comparatorIn = 1'b0;
    fullWordMode = 1'b1;
    highHalfMode = 1'b0;
    spareBits = 3'h0;
  end
  // ==========================================================
  // control word builder
  // word mode comes from word_mode; triangle mode only while the square pin is off
  function automatic logic [15:0] ctl(input logic f, p, s, en, cm, byp, md);
    return {2'h0, fullWordMode, highHalfMode, f, p, s, spareBits, en, cm, byp, 1'b0, md & ~en, 1'b0};
  endfunction
  // picks full-word or half-word loading and the bits the block leaves unused
  task automatic word_mode(input logic fw, hh, input logic [2:0] sp);
    fullWordMode = fw;
    highHalfMode = hh;
    spareBits = sp;
  endtask
  // ==========================================================
  // word writes and pin changes
  task automatic put(input logic [15:0] w);
    @(posedge ref_clk);
    #1;
    wordData = w;
    wordValid = 1'b1;
    @(posedge ref_clk);
    #1;
    wordValid = 1'b0;
    wordData = ~w;
  endtask
  // pins move just after the rising edge, far from the falling sample
  task automatic pins(input logic f, p);
    @(posedge ref_clk);
    #1;
    frequencyChoicePin = f;
    phaseChoicePin = p;
  endtask
  task automatic burst(input int edges);
    repeat (edges) begin
      repeat (4) @(posedge ref_clk);
      #1;
      comparatorIn = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      comparatorIn = 1'b0;
    end
  endtask
endmodule // dors_host
`default_nettype wire

// ---- dv/tb_top.sv ----
/*
  self-checking bench for the dds register select and output block.
  assumes dors_host as host model and a 50 MHz ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk;
  logic srst;
  logic [15:0] wordData;
  logic wordValid;
  logic frequencyChoicePin;
  logic phaseChoicePin;
  logic comparatorIn;
  logic [9:0] dacData;
  logic [9:0] dPrev;
  logic squareOut;
  logic squareOutEnN;
  logic sqPrev;
  logic dacPrev;
  int bad_count = 0;
  int n_tests = 0;
  int n;
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  dors_host u_host (.ref_clk(ref_clk), .wordData(wordData), .wordValid(wordValid),
    .frequencyChoicePin(frequencyChoicePin), .phaseChoicePin(phaseChoicePin), .comparatorIn(comparatorIn));
  dors_top u_dut (.ref_clk(ref_clk), .srst(srst), .wordData(wordData), .wordValid(wordValid),
    .frequencyChoicePin(frequencyChoicePin), .phaseChoicePin(phaseChoicePin), .comparatorIn(comparatorIn),
    .dacData(dacData), .squareOut(squareOut), .squareOutEnN(squareOutEnN));
  // ==========================================================
  // checking and closing
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // stimulus helpers
  task automatic sel(input logic [15:0] w, input logic f, p);
    u_host.put(w);
    u_host.pins(f, p);
    repeat (6) @(negedge ref_clk);
  endtask
  // cycles between two rising edges of the dac msb
  task automatic period(output int p);
    p = 0;
    repeat (2) begin
      p = 0;
      dacPrev = 1'b1;
      while (!(dacData[9] === 1'b1 && dacPrev === 1'b0) && p < 300) begin
        dacPrev = dacData[9];
        @(negedge ref_clk);
        p++;
      end
    end
  endtask
  task automatic sq_count(input logic byp, output int c);
    sel(u_host.ctl(0, 0, 0, 1, 1, byp, 0), 0, 0);
    c = 0;
    fork
      u_host.burst(8);
      begin
        sqPrev = squareOut;
        repeat (70) begin
          @(negedge ref_clk);
          if (squareOut !== sqPrev) c++;
          sqPrev = squareOut;
        end
      end
    join
  endtask
  task automatic changes(input logic md, output int c);
    u_host.put(u_host.ctl(0, 0, 0, 0, 0, 1, md));
    u_host.put(16'h4000);
    u_host.put(16'h4010);
    repeat (6) @(negedge ref_clk);
    c = 0;
    dPrev = dacData;
    repeat (1024) begin
      @(negedge ref_clk);
      if (dacData !== dPrev) c++;
      dPrev = dacData;
    end
  endtask
  // ==========================================================
  // watchdog
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  // ==========================================================
  // main sequence
  initial begin
    srst = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    @(negedge ref_clk);
    chk("dac reset", 10'h200, dacData);
    chk("enable reset", 1'b1, squareOutEnN);
    u_host.put(16'hC100);
    u_host.put(16'hE800);
    sel(u_host.ctl(0, 0, 0, 0, 0, 1, 0), 0, 0);
    chk("phase a msb", 1'b1, dacData[9]);
    sel(u_host.ctl(0, 1, 0, 0, 0, 1, 0), 0, 0);
    chk("phase b msb", 1'b0, dacData[9]);
    sel(u_host.ctl(0, 0, 1, 0, 0, 1, 0), 0, 1);
    chk("phase pin b", 1'b0, dacData[9]);
    sel(u_host.ctl(0, 1, 1, 0, 0, 1, 0), 0, 0);
    chk("phase pin a", 1'b1, dacData[9]);
    sq_count(1'b1, n);
    chk("comparator toggles", 16, n);
    chk("enable on", 1'b0, squareOutEnN);
    sq_count(1'b0, n);
    chk("halved toggles", 8, n);
    sel(u_host.ctl(0, 0, 0, 0, 0, 1, 0), 0, 0);
    chk("enable off", 1'b1, squareOutEnN);
    u_host.put(16'h4000);
    u_host.put(16'h4400);
    u_host.put(16'h8000);
    u_host.put(16'h8200);
    period(n);
    chk("period a", 16, n);
    sel(u_host.ctl(1, 0, 0, 0, 0, 1, 0), 0, 0);
    period(n);
    chk("period b", 32, n);
    sel(u_host.ctl(1, 0, 1, 0, 0, 1, 0), 0, 0);
    period(n);
    chk("period pin a", 16, n);
    sel(u_host.ctl(1, 0, 1, 0, 0, 1, 0), 1, 0);
    period(n);
    chk("period pin b", 32, n);
    u_host.word_mode(1'b0, 1'b1, 3'h5);
    sel(u_host.ctl(0, 0, 0, 0, 0, 1, 0), 0, 0);
    u_host.put(16'h4200);
    period(n);
    chk("period high half", 32, n);
    u_host.word_mode(1'b0, 1'b0, 3'h2);
    sel(u_host.ctl(0, 0, 0, 0, 0, 1, 0), 0, 0);
    u_host.put(16'h4001);
    period(n);
    chk("period low half", 32, n);
    u_host.word_mode(1'b1, 1'b0, 3'h0);
    sel(u_host.ctl(0, 0, 0, 1, 0, 1, 0), 0, 0);
    n = 0;
    repeat (40) begin
      dacPrev = dacData[9];
      @(negedge ref_clk);
      if (squareOut !== dacPrev) n++;
    end
    chk("square follows msb", 0, n);
    changes(1'b1, n);
    chk("triangle steps", 1, n > 256);
    changes(1'b0, n);
    chk("sine steps", 1, n < 200);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
